// File: pkg/acwd_pkg.sv
package acwd_pkg;

  // special-function-register addresses
  localparam logic [7:0] ACWD_ADDR_RES_LO  = 8'hbe;
  localparam logic [7:0] ACWD_ADDR_RES_HI  = 8'hbf;
  localparam logic [7:0] ACWD_ADDR_ABV_LO  = 8'hc4;
  localparam logic [7:0] ACWD_ADDR_ABV_HI  = 8'hc5;
  localparam logic [7:0] ACWD_ADDR_BLW_LO  = 8'hc6;
  localparam logic [7:0] ACWD_ADDR_BLW_HI  = 8'hc7;
  localparam logic [7:0] ACWD_ADDR_CTRL    = 8'he8;

  // reset values
  localparam logic [7:0] ACWD_RST_RES_LO   = 8'h00;
  localparam logic [7:0] ACWD_RST_RES_HI   = 8'h00;
  localparam logic [7:0] ACWD_RST_ABV_LO   = 8'hff;
  localparam logic [7:0] ACWD_RST_ABV_HI   = 8'hff;
  localparam logic [7:0] ACWD_RST_BLW_LO   = 8'h00;
  localparam logic [7:0] ACWD_RST_BLW_HI   = 8'h00;
  localparam logic [7:0] ACWD_RST_CTRL     = 8'h00;
  localparam logic [7:0] ACWD_RD_UNMAPPED  = 8'h00;

  // start-source field encodings
  localparam logic [1:0] ACWD_SRC_SW       = 2'h0;
  localparam logic [1:0] ACWD_SRC_T3       = 2'h1;
  localparam logic [1:0] ACWD_SRC_PIN      = 2'h2;
  localparam logic [1:0] ACWD_SRC_T2       = 2'h3;

  // timing in sar clock periods
  localparam int unsigned ACWD_TRACK_SAR_CLKS = 3;
  localparam int unsigned ACWD_CONV_SAR_CLKS  = 12;

  // control register, field order is bit 7 down to bit 0
  typedef struct packed {
    logic       converter_on;
    logic       track_select;
    logic       conv_done_flag;
    logic       conv_in_progress;
    logic [1:0] start_source_sel;
    logic       window_hit_flag;
    logic       left_align_sel;
  } acwd_ctrl_type;

  // one register-space access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } acwd_sfr_req_type;

  typedef enum logic [1:0] {
    ACWD_IDLE,
    ACWD_TRACK,
    ACWD_CONV
  } acwd_state_type;

endpackage : acwd_pkg

// File: verilog/acwd_top.sv
`timescale 1ns/10ps
module acwd_top #(
  parameter int unsigned CONV_SAR_CLKS = acwd_pkg::ACWD_CONV_SAR_CLKS
) (
  input  wire logic                       i_clk_sys,   // system clock
  input  wire logic                       i_rst,       // sync reset, high
  input  wire acwd_pkg::acwd_sfr_req_type i_sfr_req,   // register access
  output logic [7:0]                      o_sfr_rdata, // read data, +1 cyc
  input  wire logic                       i_sar_tick,  // sar clock enable
  input  wire logic                       i_timer2_ovf, // timer 2 overflow
  input  wire logic                       i_timer3_ovf, // timer 3 overflow
  input  wire logic                       i_ext_start_pin, // async pin
  input  wire logic                       i_diff_mode, // differential pair
  input  wire logic [11:0]                i_sar_code,  // converter code
  output logic                            o_power_on,  // analog powered
  output logic                            o_track,     // sample switch on
  output logic                            o_converting, // sar running
  output logic                            o_busy_fall  // end pulse
);
  import acwd_pkg::*;

  localparam logic [1:0] TRK_LAST = 2'(ACWD_TRACK_SAR_CLKS - 1);
  localparam logic [7:0] CNV_LAST = 8'(CONV_SAR_CLKS - 1);

  acwd_ctrl_type  ctrl_r;
  acwd_ctrl_type  ctrl_nxt;
  acwd_state_type state_r;
  acwd_state_type state_nxt;
  logic [15:0]    result_r;
  logic [15:0]    result_nxt;
  logic [7:0]     abv_lo_r;
  logic [7:0]     abv_hi_r;
  logic [7:0]     blw_lo_r;
  logic [7:0]     blw_hi_r;
  logic [7:0]     rdata_r;
  logic [7:0]     rdata_nxt;
  logic [1:0]     trk_cnt_r;
  logic [1:0]     trk_cnt_nxt;
  logic [7:0]     cnv_cnt_r;
  logic [7:0]     cnv_cnt_nxt;
  logic           pin_meta_r;
  logic           pin_sync_r;
  logic           pin_prev_r;
  logic           busy_fall_r;

  // address decode
  wire wr_ctrl   = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_CTRL);
  wire wr_res_lo = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_RES_LO);
  wire wr_res_hi = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_RES_HI);
  wire wr_abv_lo = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_ABV_LO);
  wire wr_abv_hi = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_ABV_HI);
  wire wr_blw_lo = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_BLW_LO);
  wire wr_blw_hi = i_sfr_req.wr && (i_sfr_req.addr == ACWD_ADDR_BLW_HI);
  acwd_ctrl_type wr_ctl_val;
  assign wr_ctl_val = acwd_ctrl_type'(i_sfr_req.wdata);

  // start sources; pin edge is taken after the synchroniser only
  wire busy      = (state_r != ACWD_IDLE);
  wire pin_rise  = pin_sync_r && !pin_prev_r;
  wire sw_start  = wr_ctrl && wr_ctl_val.conv_in_progress
                   && (ctrl_r.start_source_sel == ACWD_SRC_SW);
  wire start_evt =
    (ctrl_r.start_source_sel == ACWD_SRC_SW)  ? sw_start     :
    (ctrl_r.start_source_sel == ACWD_SRC_T3)  ? i_timer3_ovf :
    (ctrl_r.start_source_sel == ACWD_SRC_PIN) ? pin_rise     :
                                                i_timer2_ovf;
  // pin source has no timed track phase: the low level was the track
  wire timed_trk = ctrl_r.track_select
                   && (ctrl_r.start_source_sel != ACWD_SRC_PIN);
  wire sar_last  = i_sar_tick && (cnv_cnt_r == CNV_LAST);
  // an abort by converter off must not post flags or a result
  wire finish    = (state_r == ACWD_CONV) && sar_last
                   && ctrl_r.converter_on;

  // result formatting, alignment as currently selected
  wire [3:0]  sign_nib = i_diff_mode ? {4{i_sar_code[11]}} : 4'h0;
  wire [15:0] fmt_res  = ctrl_r.left_align_sel
                         ? {i_sar_code, 4'h0}
                         : {sign_nib, i_sar_code};

  // window compare on 17-bit values so one compare serves both modes
  wire [15:0] abv_word = {abv_hi_r, abv_lo_r};
  wire [15:0] blw_word = {blw_hi_r, blw_lo_r};
  wire        sgn      = i_diff_mode;
  wire signed [16:0] res_x = {sgn & fmt_res[15], fmt_res};
  wire signed [16:0] abv_x = {sgn & abv_word[15], abv_word};
  wire signed [16:0] blw_x = {sgn & blw_word[15], blw_word};
  wire above_hit = res_x > abv_x;
  wire below_hit = res_x < blw_x;
  wire win_hit   = (blw_x > abv_x) ? (above_hit && below_hit)
                                   : (above_hit || below_hit);

  // state sequencing
  always_comb begin
    state_nxt   = state_r;
    trk_cnt_nxt = trk_cnt_r;
    cnv_cnt_nxt = cnv_cnt_r;
    unique case (state_r)
      ACWD_IDLE: begin
        trk_cnt_nxt = 2'h0;
        cnv_cnt_nxt = 8'h00;
        if (start_evt) begin
          state_nxt = timed_trk ? ACWD_TRACK : ACWD_CONV;
        end
      end
      ACWD_TRACK: begin
        if (i_sar_tick) begin
          trk_cnt_nxt = trk_cnt_r + 2'h1;
          if (trk_cnt_r == TRK_LAST) begin
            state_nxt = ACWD_CONV;
          end
        end
      end
      ACWD_CONV: begin
        // further starts fall through unseen here
        if (i_sar_tick) begin
          cnv_cnt_nxt = cnv_cnt_r + 8'h01;
        end
        if (sar_last) begin
          state_nxt = ACWD_IDLE;
        end
      end
    endcase
    if (!ctrl_r.converter_on) begin
      state_nxt = ACWD_IDLE;
    end
  end

  // control register; hardware set beats a software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wr_ctl_val;
    end
    ctrl_nxt.conv_in_progress = 1'b0;
    if (finish) begin
      ctrl_nxt.conv_done_flag = 1'b1;
      if (win_hit) begin
        ctrl_nxt.window_hit_flag = 1'b1;
      end
    end
  end

  // result bytes may be overwritten by software between conversions
  always_comb begin
    result_nxt = result_r;
    if (wr_res_lo) begin
      result_nxt[7:0] = i_sfr_req.wdata;
    end
    if (wr_res_hi) begin
      result_nxt[15:8] = i_sfr_req.wdata;
    end
    if (finish) begin
      result_nxt = fmt_res;
    end
  end

  // read mux, registered so data leaves from flops
  always_comb begin
    rdata_nxt = ACWD_RD_UNMAPPED;
    unique case (i_sfr_req.addr)
      ACWD_ADDR_RES_LO: rdata_nxt = result_r[7:0];
      ACWD_ADDR_RES_HI: rdata_nxt = result_r[15:8];
      ACWD_ADDR_ABV_LO: rdata_nxt = abv_lo_r;
      ACWD_ADDR_ABV_HI: rdata_nxt = abv_hi_r;
      ACWD_ADDR_BLW_LO: rdata_nxt = blw_lo_r;
      ACWD_ADDR_BLW_HI: rdata_nxt = blw_hi_r;
      ACWD_ADDR_CTRL: begin
        rdata_nxt    = ctrl_r;
        rdata_nxt[4] = busy;
      end
      default: rdata_nxt = ACWD_RD_UNMAPPED;
    endcase
    if (!i_sfr_req.rd) begin
      rdata_nxt = rdata_r;
    end
  end

  // main state and registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r   <= ACWD_IDLE;
      ctrl_r    <= acwd_ctrl_type'(ACWD_RST_CTRL);
      result_r  <= {ACWD_RST_RES_HI, ACWD_RST_RES_LO};
      rdata_r   <= ACWD_RD_UNMAPPED;
      trk_cnt_r <= 2'h0;
      cnv_cnt_r <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt;
      result_r  <= result_nxt;
      rdata_r   <= rdata_nxt;
      trk_cnt_r <= trk_cnt_nxt;
      cnv_cnt_r <= cnv_cnt_nxt;
    end
  end

  // limit registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      abv_lo_r <= ACWD_RST_ABV_LO;
      abv_hi_r <= ACWD_RST_ABV_HI;
      blw_lo_r <= ACWD_RST_BLW_LO;
      blw_hi_r <= ACWD_RST_BLW_HI;
    end else begin
      if (wr_abv_lo) abv_lo_r <= i_sfr_req.wdata;
      if (wr_abv_hi) abv_hi_r <= i_sfr_req.wdata;
      if (wr_blw_lo) blw_lo_r <= i_sfr_req.wdata;
      if (wr_blw_hi) blw_hi_r <= i_sfr_req.wdata;
    end
  end

  // pin synchroniser; meta flop feeds only the sync flop
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_meta_r <= i_ext_start_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // end-of-conversion pulse, the busy falling edge after a finish; an abort gives none
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy_fall_r <= 1'b0;
    end else begin
      busy_fall_r <= finish;
    end
  end

  // analog-facing controls
  wire pin_track = ctrl_r.track_select
                   && (ctrl_r.start_source_sel == ACWD_SRC_PIN)
                   && (state_r == ACWD_IDLE) && !pin_sync_r;
  wire free_track = !ctrl_r.track_select && (state_r != ACWD_CONV);
  assign o_power_on   = ctrl_r.converter_on;
  assign o_track      = ctrl_r.converter_on
                        && (free_track || pin_track
                            || (state_r == ACWD_TRACK));
  assign o_converting = (state_r == ACWD_CONV);
  assign o_busy_fall  = busy_fall_r;
  assign o_sfr_rdata  = rdata_r;

  // helper: sar ticks seen in the track phase
  logic [3:0] trk_seen_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_r != ACWD_TRACK) trk_seen_r <= 4'h0;
    else if (i_sar_tick) trk_seen_r <= trk_seen_r + 4'h1;
  end

  AST_OFF_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_r.converter_on |=> !o_converting)
    else $error("conversion while converter off");
  AST_FREE_TRACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_r.converter_on && !ctrl_r.track_select && !o_converting
    |-> o_track)
    else $error("not tracking in free track mode");
  AST_TRACK_LEN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == ACWD_TRACK) && (state_nxt == ACWD_CONV) && !i_rst
    |-> (trk_seen_r == 4'h2) && i_sar_tick)
    else $error("track phase not three sar clocks");
  AST_PIN_TRACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_r.converter_on && ctrl_r.track_select && !busy
    && (ctrl_r.start_source_sel == ACWD_SRC_PIN)
    |-> (o_track == !pin_sync_r))
    else $error("pin track level wrong");
  AST_SW_START: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sw_start && ctrl_r.converter_on && !busy |=> busy)
    else $error("software start lost");
  AST_SW_IGNORED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_ctrl && !busy && (ctrl_r.start_source_sel != ACWD_SRC_SW)
    && !start_evt |=> !busy)
    else $error("busy write started in wrong source");
  AST_T3_START: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_timer3_ovf && ctrl_r.converter_on && !busy
    && (ctrl_r.start_source_sel == ACWD_SRC_T3) |=> busy)
    else $error("timer 3 start lost");
  AST_T2_START: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_timer2_ovf && ctrl_r.converter_on && !busy
    && (ctrl_r.start_source_sel == ACWD_SRC_T2) |=> busy)
    else $error("timer 2 start lost");
  AST_PIN_START: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pin_rise && ctrl_r.converter_on && !busy
    && (ctrl_r.start_source_sel == ACWD_SRC_PIN)
    |=> (state_r == ACWD_CONV))
    else $error("pin edge start lost");
  AST_DONE_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish |=> ctrl_r.conv_done_flag ##0 o_busy_fall)
    else $error("done flag or end pulse missing");
  AST_DONE_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_r.conv_done_flag && !wr_ctrl |=> ctrl_r.conv_done_flag)
    else $error("done flag cleared by hardware");
  AST_WIN_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish && win_hit |=> ctrl_r.window_hit_flag
    && ctrl_r.conv_done_flag)
    else $error("window flag not set with done");
  AST_LEFT_LOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish && ctrl_r.left_align_sel |=> (result_r[3:0] == 4'h0))
    else $error("left aligned low nibble not zero");
  AST_BUSY_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    busy && ctrl_r.converter_on && !finish |=> busy)
    else $error("busy dropped before finish");

  // shutdown, track switch, end pulse, readback and result layout
  AST_OFF_NOTRK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_r.converter_on |-> !o_track)
    else $error("tracking while converter off");
  AST_OFF_NODONE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_r.converter_on && !ctrl_r.conv_done_flag && !wr_ctrl
    |=> !ctrl_r.conv_done_flag)
    else $error("done flag set while converter off");
  AST_CONV_NOTRK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_converting |-> !o_track)
    else $error("tracking during conversion");
  AST_ZERO_TRK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    start_evt && ctrl_r.converter_on && !busy && !ctrl_r.track_select
    |=> o_converting)
    else $error("free track start did not convert at once");
  AST_TIMED_TRK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    start_evt && ctrl_r.converter_on && !busy && ctrl_r.track_select
    && (ctrl_r.start_source_sel != ACWD_SRC_PIN)
    |=> (state_r == ACWD_TRACK))
    else $error("timed start skipped the track phase");
  AST_FALL_ONCE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_busy_fall |=> !o_busy_fall)
    else $error("end pulse longer than one cycle");
  AST_FALL_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_busy_fall |-> !busy)
    else $error("end pulse while still busy");
  AST_BUSY_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_sfr_req.rd && (i_sfr_req.addr == ACWD_ADDR_CTRL)
    |=> (o_sfr_rdata[4] == $past(busy)))
    else $error("busy bit readback wrong");
  AST_WR0_NOP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_ctrl && !wr_ctl_val.conv_in_progress && !busy
    && (ctrl_r.start_source_sel == ACWD_SRC_SW) |=> !busy)
    else $error("writing zero to busy started a conversion");
  AST_WIN_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_r.window_hit_flag && !wr_ctrl |=> ctrl_r.window_hit_flag)
    else $error("window flag cleared by hardware");
  AST_RIGHT_SE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish && !ctrl_r.left_align_sel && !i_diff_mode
    |=> (result_r[15:12] == 4'h0))
    else $error("single-ended high nibble not zero");
  AST_RIGHT_DIFF: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish && !ctrl_r.left_align_sel && i_diff_mode
    |=> (result_r[15:12] == {4{result_r[11]}}))
    else $error("differential high nibble not sign copy");
  AST_LEFT_HI: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    finish && ctrl_r.left_align_sel
    |=> (result_r[15:4] == $past(i_sar_code)))
    else $error("left aligned code misplaced");

endmodule : acwd_top

// File: testbench/acwd_far_model.sv
`timescale 1ns/10ps
// sar clock enables and the two timer overflows seen by the converter
module acwd_far_model #(
  parameter int unsigned TICK_DIV = 8 // system clocks per sar clock
) (
  input  wire logic i_clk_sys,    // system clock
  input  wire logic i_rst,        // sync reset, high
  input  wire logic i_fire_t2,    // bench asks for a timer 2 overflow
  input  wire logic i_fire_t3,    // bench asks for a timer 3 overflow
  output logic      o_sar_tick,   // one cycle per sar period
  output logic      o_timer2_ovf, // overflow pulse
  output logic      o_timer3_ovf  // overflow pulse
);
  int unsigned div_cnt;

  // divider runs free, so starts land at any sar phase
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_cnt    <= 0;
      o_sar_tick <= 1'b0;
    end else begin
      div_cnt    <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      o_sar_tick <= (div_cnt == TICK_DIV - 1);
    end
  end

  // each overflow is the request delayed one system clock, as wide as the request
  always_ff @(posedge i_clk_sys) begin
    o_timer2_ovf <= i_fire_t2 & ~i_rst;
    o_timer3_ovf <= i_fire_t3 & ~i_rst;
  end
endmodule : acwd_far_model

// File: testbench/acwd_top_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module acwd_top_tb;
  import acwd_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  acwd_sfr_req_type req = '0;
  logic [7:0]       rdata, d;
  logic             fire2 = 1'b0, fire3 = 1'b0, pin = 1'b1, diff = 1'b0;
  logic [11:0]      code = '0;
  logic             tick, t2, t3, pwr, trk, cnv, bfall;
  int               n_errors = 0, n_tests = 0, n_fall = 0;
  logic [7:0]       ra [8] = '{ACWD_ADDR_RES_LO, ACWD_ADDR_RES_HI,
    ACWD_ADDR_ABV_LO, ACWD_ADDR_ABV_HI, ACWD_ADDR_BLW_LO, ACWD_ADDR_BLW_HI,
    ACWD_ADDR_CTRL, 8'h55};
  logic [7:0]       rv [8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00};

  always #5 clk = ~clk;
  // completions counted from the end pulse
  always @(posedge clk) if (bfall === 1'b1) n_fall <= n_fall + 1;

  acwd_top #(.CONV_SAR_CLKS(2)) uut (.i_clk_sys(clk), .i_rst(rst),
    .i_sfr_req(req), .o_sfr_rdata(rdata), .i_sar_tick(tick),
    .i_timer2_ovf(t2), .i_timer3_ovf(t3), .i_ext_start_pin(pin),
    .i_diff_mode(diff), .i_sar_code(code), .o_power_on(pwr),
    .o_track(trk), .o_converting(cnv), .o_busy_fall(bfall));
  acwd_far_model far (.i_clk_sys(clk), .i_rst(rst), .i_fire_t2(fire2),
    .i_fire_t3(fire3), .o_sar_tick(tick), .o_timer2_ovf(t2),
    .o_timer3_ovf(t3));

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge clk);
    #1 req = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    v = rdata;
  endtask : rd

  // start by the selected source; pin waits out its synchroniser
  task automatic kick(input logic [1:0] s, input logic [7:0] c);
    if (s == 2'h0) wr(ACWD_ADDR_CTRL, c | 8'h10);
    else if (s == 2'h2) begin
      @(posedge clk);
      #1 pin = 1'b0;
      repeat (6) @(posedge clk);
      #1 pin = 1'b1;
      repeat (4) @(posedge clk);
    end else begin
      @(posedge clk);
      #1 fire3 = (s == 2'h1);
      fire2 = (s == 2'h3);
      @(posedge clk);
      #1 fire3 = 1'b0;
      fire2 = 1'b0;
    end
  endtask : kick

  task automatic wait_fall(input int n0);
    int k;
    k = 0;
    while (n_fall == n0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      n_errors++;
      $display("ERROR t=%0t no completion", $time);
    end
    #1;
  endtask : wait_fall

  // one conversion: limits, start, busy, restart attempt (not for pin source), flags, result
  task automatic run(input logic [1:0] s, input logic tm, la, dm,
    input logic [11:0] c, input logic [15:0] blw, abv, res,
    input logic win);
    logic [7:0] ctl, hi;
    int         n0;
    ctl  = {1'b1, tm, 2'b00, s, 1'b0, la};
    diff = dm;
    code = c;
    wr(ACWD_ADDR_BLW_HI, blw[15:8]);
    wr(ACWD_ADDR_BLW_LO, blw[7:0]);
    wr(ACWD_ADDR_ABV_HI, abv[15:8]);
    wr(ACWD_ADDR_ABV_LO, abv[7:0]);
    wr(ACWD_ADDR_CTRL, ctl);
    n0 = n_fall;
    kick(s, ctl);
    rd(ACWD_ADDR_CTRL, d);
    `CHK(d[4], 1'b1)
    `CHK(cnv, !tm || s == 2'h2)
    `CHK(trk, tm && s != 2'h2)
    if (s != 2'h2) kick(s, ctl);
    wait_fall(n0);
    repeat (8) @(posedge clk);
    `CHK(n_fall, n0 + 1)
    rd(ACWD_ADDR_CTRL, d);
    `CHK(d, ctl | 8'h20 | {6'h00, win, 1'b0})
    rd(ACWD_ADDR_RES_HI, hi);
    rd(ACWD_ADDR_RES_LO, d);
    `CHK({hi, d}, res)
  endtask : run

  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    `CHK(pwr, 1'b0)
    wr(8'h55, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      `CHK(d, rv[i])
    end
    wr(ACWD_ADDR_CTRL, 8'h10);
    repeat (40) @(posedge clk);
    `CHK(n_fall, 0)
    `CHK(cnv, 1'b0)
    `CHK(pwr, 1'b0)
    wr(ACWD_ADDR_CTRL, 8'h80);
    `CHK(pwr, 1'b1)
    `CHK(trk, 1'b1)
    wr(ACWD_ADDR_CTRL, 8'hc0);
    `CHK(trk, 1'b0)
    wr(ACWD_ADDR_CTRL, 8'h84);
    wr(ACWD_ADDR_CTRL, 8'h94);
    kick(2'h3, 8'h84);
    repeat (60) @(posedge clk);
    rd(ACWD_ADDR_CTRL, d);
    `CHK(d, 8'h84)
    `CHK(n_fall, 0)
    wr(ACWD_ADDR_CTRL, 8'hc8);
    `CHK(trk, 1'b0)
    pin = 1'b0;
    repeat (5) @(posedge clk);
    #1 pin = 1'b1;
    `CHK(trk, 1'b1)
    wait_fall(0);
    run(0, 0, 0, 0, 12'h101, 16'h0200, 16'h0100, 16'h0101, 1);
    run(0, 0, 0, 0, 12'h100, 16'h0200, 16'h0100, 16'h0100, 0);
    run(0, 0, 0, 0, 12'h1ff, 16'h0200, 16'h0100, 16'h01ff, 1);
    run(0, 0, 0, 0, 12'h200, 16'h0200, 16'h0100, 16'h0200, 0);
    run(1, 1, 0, 0, 12'h0ff, 16'h0100, 16'h0200, 16'h00ff, 1);
    run(3, 1, 0, 0, 12'h201, 16'h0100, 16'h0200, 16'h0201, 1);
    run(2, 1, 0, 0, 12'h150, 16'h0100, 16'h0200, 16'h0150, 0);
    run(0, 1, 1, 0, 12'hfff, 16'h0000, 16'hffff, 16'hfff0, 0);
    run(0, 0, 0, 0, 12'h000, 16'h0000, 16'hffff, 16'h0000, 0);
    run(0, 0, 0, 0, 12'hfff, 16'h0000, 16'hffff, 16'h0fff, 0);
    run(0, 0, 0, 1, 12'h800, 16'h0000, 16'hffff, 16'hf800, 0);
    run(0, 0, 1, 1, 12'h800, 16'h0000, 16'hffff, 16'h8000, 0);
    run(0, 0, 0, 1, 12'h7ff, 16'h0000, 16'hffff, 16'h07ff, 0);
    run(0, 0, 0, 1, 12'h000, 16'h0100, 16'hffff, 16'h0000, 1);
    run(0, 0, 0, 1, 12'hfff, 16'h0100, 16'hffff, 16'hffff, 0);
    run(0, 0, 1, 0, 12'h150, 16'h2000, 16'h1000, 16'h1500, 1);
    wr(ACWD_ADDR_CTRL, 8'h80);
    rd(ACWD_ADDR_CTRL, d);
    `CHK(d, 8'h80)
    print_verdict();
  end
endmodule : acwd_top_tb
